/* core/gsl_encoder.sv */
// Purpose: Gateway status LED encoder with register port and interrupt
// Assumes: State inputs come from pins, resynchronised here
// Notes: Fatal beats exception beats everything else on the LEDs; exception leaves statusSym alone
`timescale 1ns/1ps
`default_nettype none
module gsl_encoder #(
   parameter int HALF_CYC = gsl_pkg::GSL_FLASH_HALF_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [5:0] gwPhase,
   input wire logic fatalErr,
   input wire logic exceptErr,
   input wire logic internalErr,
   input wire logic outOfSpec,
   input wire logic compStartup,
   input wire logic eipHasAddr,
   input wire logic eipConnUp,
   input wire logic eipDupAddr,
   input wire logic eipConnTmo,
   input wire logic mbHasAddr,
   input wire logic mbMsgSeen,
   input wire logic mbAddrConf,
   input wire logic mbConnTmo,
   input wire logic secLocked,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   output logic irq,
   output logic [1:0] gwLed,
   output logic [1:0] eipLed,
   output logic [1:0] mbLed,
   output logic secLed,
   output gsl_pkg::gsl_sym_e statusSym
);
   import gsl_pkg::*;
   localparam int NIN = 20;
   gsl_flash_if fl ();
   gsl_flash_div #(.HALF_CYC(HALF_CYC)) uDiv (
      .mclk(mclk),
      .rst_n(rst_n),
      .fl(fl)
   );
   // Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] s1_ff, s2_ff, s3_ff, in_ff;
   assign rawIn = {gwPhase, fatalErr, exceptErr, internalErr, outOfSpec,
      compStartup, eipHasAddr, eipConnUp, eipDupAddr, eipConnTmo,
      mbHasAddr, mbMsgSeen, mbAddrConf, mbConnTmo, secLocked};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= rawIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : gSync
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               in_ff[gi] <= 1'b0;
            end else if (s2_ff[gi] == s3_ff[gi]) begin
               in_ff[gi] <= s3_ff[gi];
            end
         end
      end
   endgenerate
   logic [5:0] sGw;
   logic sFatal, sExc, sInt, sOos, sComp;
   logic sEipAdr, sEipUp, sEipDup, sEipTmo;
   logic sMbAdr, sMbMsg, sMbConf, sMbTmo, sLock;
   assign {sGw, sFatal, sExc, sInt, sOos, sComp, sEipAdr, sEipUp, sEipDup,
      sEipTmo, sMbAdr, sMbMsg, sMbConf, sMbTmo, sLock} = in_ff;

   function automatic logic [1:0] flashOf(input logic [1:0] col,
      input logic ph);
      flashOf = ph ? col : GSL_LED_OFF;
   endfunction : flashOf

   logic [1:0] nxt_gwLed, nxt_eipLed, nxt_mbLed;
   logic nxt_secLed;
   gsl_sym_e nxt_sym;
   logic ph;
   assign ph = fl.phase;

   always_comb begin
      nxt_gwLed = GSL_LED_OFF;
      if (sFatal || sExc) begin
         nxt_gwLed = GSL_LED_RED;
      end else begin
         unique case (sGw)
            GSL_GW_START: nxt_gwLed = flashOf(GSL_LED_GRN, ph);
            GSL_GW_RUN: nxt_gwLed = GSL_LED_GRN;
            GSL_GW_BADCFG: nxt_gwLed = flashOf(GSL_LED_RED, ph);
            GSL_GW_SELFTEST,
            GSL_GW_UPDATE: nxt_gwLed = ph ? GSL_LED_RED : GSL_LED_GRN;
            default: nxt_gwLed = GSL_LED_OFF; // Illegal or off phase
         endcase
      end
   end

   always_comb begin
      if (sFatal) begin
         nxt_eipLed = GSL_LED_RED;
      end else if (sExc) begin
         nxt_eipLed = GSL_LED_OFF;
      end else if (!sEipAdr) begin
         nxt_eipLed = GSL_LED_OFF;
      end else if (sEipDup) begin
         nxt_eipLed = GSL_LED_RED;
      end else if (sEipTmo) begin
         nxt_eipLed = flashOf(GSL_LED_RED, ph);
      end else if (sEipUp) begin
         nxt_eipLed = GSL_LED_GRN;
      end else begin
         nxt_eipLed = flashOf(GSL_LED_GRN, ph);
      end
   end

   always_comb begin
      if (sFatal) begin
         nxt_mbLed = GSL_LED_RED;
      end else if (sExc) begin
         nxt_mbLed = GSL_LED_OFF;
      end else if (!sMbAdr) begin
         nxt_mbLed = GSL_LED_OFF;
      end else if (sMbConf) begin
         nxt_mbLed = GSL_LED_RED;
      end else if (sMbTmo) begin
         nxt_mbLed = flashOf(GSL_LED_RED, ph);
      end else if (sMbMsg) begin
         nxt_mbLed = GSL_LED_GRN;
      end else begin
         nxt_mbLed = flashOf(GSL_LED_GRN, ph);
      end
   end

   // Dark in both error states, even if the switch stays locked
   assign nxt_secLed = sLock && !sFatal && !sExc;

   always_comb begin
      if (sInt || sFatal) begin
         nxt_sym = GSL_SYM_INTERR;
      end else if (sComp || sGw == GSL_GW_START || sGw == GSL_GW_BADCFG ||
         (sEipAdr && !sEipUp) || (sMbAdr && !sMbMsg)) begin
         nxt_sym = GSL_SYM_CHECK;
      end else if (sOos) begin
         nxt_sym = GSL_SYM_OUTSPEC;
      end else begin
         nxt_sym = GSL_SYM_NORMAL;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gwLed <= GSL_LED_RST;
         eipLed <= GSL_LED_RST;
         mbLed <= GSL_LED_RST;
         secLed <= 1'b0;
         statusSym <= GSL_SYM_NORMAL;
      end else begin
         gwLed <= nxt_gwLed;
         eipLed <= nxt_eipLed;
         mbLed <= nxt_mbLed;
         secLed <= nxt_secLed;
         statusSym <= nxt_sym;
      end
   end

   // Events: fatal, exception, internal, eip dup, eip tmo, mb conf, mb tmo,
   // security lock change
   logic [7:0] evt, evtPrev_ff, status_ff, mask_ff, nxt_status;
   logic [7:0] evtLvl;
   assign evtLvl = {sLock, sMbTmo, sMbConf, sEipTmo, sEipDup, sInt, sExc,
      sFatal};
   assign evt = (evtLvl & ~evtPrev_ff) | {(evtLvl[7] ^ evtPrev_ff[7]), 7'h00};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evtPrev_ff <= GSL_IRQ_RST;
      end else begin
         evtPrev_ff <= evtLvl;
      end
   end
   // Set wins over the read-clear in the same cycle
   always_comb begin
      nxt_status = status_ff;
      if (regRd && regAddr == GSL_ADR_STATUS) begin
         nxt_status = 8'h00;
      end
      nxt_status = nxt_status | evt;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= GSL_IRQ_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_ff <= GSL_MASK_RST;
      end else if (regWr && regAddr == GSL_ADR_MASK) begin
         mask_ff <= regWdata;
      end
   end
   assign irq = |(status_ff & mask_ff);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            GSL_ADR_STATUS: regRdata <= status_ff;
            GSL_ADR_MASK: regRdata <= mask_ff;
            GSL_ADR_LEDS: regRdata <= {secLed, mbLed, eipLed, gwLed, 1'b0};
            GSL_ADR_INPUT: regRdata <= {sFatal, sExc, sInt, sLock, sEipAdr,
               sEipUp, sMbAdr, sMbMsg};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   a_fatal_all_red: assert property (@(posedge mclk) disable iff (!rst_n)
      sFatal |=> (gwLed == GSL_LED_RED && eipLed == GSL_LED_RED &&
      mbLed == GSL_LED_RED && !secLed))
      else $error("fatal did not force red indicators");
   a_exc_links_off: assert property (@(posedge mclk) disable iff (!rst_n)
      (sExc && !sFatal) |=> (gwLed == GSL_LED_RED && eipLed == GSL_LED_OFF &&
      mbLed == GSL_LED_OFF && !secLed))
      else $error("exception pattern wrong");
   a_gw_run_green: assert property (@(posedge mclk) disable iff (!rst_n)
      (sGw == GSL_GW_RUN && !sFatal && !sExc) |=> gwLed == GSL_LED_GRN)
      else $error("gateway not steady green when running");
   a_sym_interr: assert property (@(posedge mclk) disable iff (!rst_n)
      sInt |=> statusSym == GSL_SYM_INTERR)
      else $error("internal error symbol missing");
   a_sym_check: assert property (@(posedge mclk) disable iff (!rst_n)
      (sComp && !sInt && !sFatal) |=> statusSym == GSL_SYM_CHECK)
      else $error("check function symbol missing");
   a_mb_msg_green: assert property (@(posedge mclk) disable iff (!rst_n)
      (sMbAdr && sMbMsg && !sMbConf && !sMbTmo && !sFatal && !sExc)
      |=> mbLed == GSL_LED_GRN)
      else $error("modbus not steady green");
   a_mb_noaddr_off: assert property (@(posedge mclk) disable iff (!rst_n)
      (!sMbAdr && !sFatal) |=> mbLed == GSL_LED_OFF)
      else $error("modbus lit without address");
   a_eip_dup_red: assert property (@(posedge mclk) disable iff (!rst_n)
      (sEipAdr && sEipDup && !sFatal && !sExc) |=> eipLed == GSL_LED_RED)
      else $error("duplicate address not red");
   a_eip_noaddr_off: assert property (@(posedge mclk) disable iff (!rst_n)
      (!sEipAdr && !sFatal) |=> eipLed == GSL_LED_OFF)
      else $error("eip lit without address");
   a_eip_flash_grn: assert property (@(posedge mclk) disable iff (!rst_n)
      (sEipAdr && !sEipUp && !sEipDup && !sEipTmo && !sFatal && !sExc)
      |=> eipLed == (ph ? GSL_LED_GRN : GSL_LED_OFF) || $changed(ph))
      else $error("eip not flashing green");
   a_sec_locked: assert property (@(posedge mclk) disable iff (!rst_n)
      (sLock && !sFatal && !sExc) |=> secLed)
      else $error("security lamp dark while locked");
endmodule : gsl_encoder
`default_nettype wire

/* core/gsl_flash_div.sv */
// Purpose: Free-running flash divider
// Assumes: HALF_CYC at least two
// Notes: Single source keeps every LED in phase
`timescale 1ns/1ps
`default_nettype none
module gsl_flash_div #(
   parameter int HALF_CYC = gsl_pkg::GSL_FLASH_HALF_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   gsl_flash_if.src fl
);
   import gsl_pkg::*;
   logic [GSL_CNT_W-1:0] cnt_ff;
   logic phase_ff;
   logic wrap;
   assign wrap = (cnt_ff == GSL_CNT_W'(HALF_CYC - 1));
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (wrap) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= 1'b0;
      end else if (wrap) begin
         phase_ff <= ~phase_ff;
      end
   end
   assign fl.phase = phase_ff;
   assign fl.tick = wrap;
   a_flash_period: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(phase_ff) |-> $past(wrap))
      else $error("flash phase moved without divider wrap");
endmodule : gsl_flash_div
`default_nettype wire

/* dv/gsl_led_watch.sv */
// Purpose: Operator view of one front-panel indicator
// Assumes: led bit1 red, bit0 green, looked at every mclk
// Notes: Flags are sticky while watch is high, cleared while low
`timescale 1ns/1ps
`default_nettype none
module gsl_led_watch (
   input wire logic mclk,
   input wire logic [1:0] led,
   input wire logic watch,
   output logic [2:0] seen
);
   // Bit2 red lit, bit1 green lit, bit0 dark
   // Sticky flags, since an eye cannot time a blink but sees each colour
   always_ff @(posedge mclk) begin
      if (!watch) begin
         seen <= 3'h0;
      end else begin
         seen <= seen | {led[1], led[0], led == 2'h0};
      end
   end
endmodule : gsl_led_watch
`default_nettype wire

/* dv/tb.sv */
// Purpose: Random and corner checks of the status LED encoder
// Assumes: HALF_CYC of 4, so one flash period is 8 cycles
// Notes: Each vector settles, is watched 16 cycles, then registers read
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin \
   errorCnt++; $display("Error %s expected %0h seen %0h", nm, ex, gt); \
   end end
module tb;
   import gsl_pkg::*;
   localparam int HALF = 4;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] gwPhase = 6'h01;
   logic [13:0] inp = 14'h0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic watch = 1'b0;
   logic [7:0] regRdata;
   logic irq;
   logic [1:0] gwLed, eipLed, mbLed;
   logic secLed;
   gsl_sym_e statusSym;
   logic [2:0] gwSeen, eipSeen, mbSeen, secSeen;
   logic [13:0] prev, nxt, rs;
   logic [5:0] ph;
   logic [31:0] w;
   logic [7:0] mask, d, ev;
   logic [2:0] eg, ee, em;
   int skew, cyc, errorCnt, testsRun;

   gsl_encoder #(.HALF_CYC(HALF)) dut_u (.mclk(mclk), .rst_n(rst_n),
      .gwPhase(gwPhase), .fatalErr(inp[0]), .exceptErr(inp[1]),
      .internalErr(inp[2]), .outOfSpec(inp[3]), .compStartup(inp[4]),
      .eipHasAddr(inp[5]), .eipConnUp(inp[6]), .eipDupAddr(inp[7]),
      .eipConnTmo(inp[8]), .mbHasAddr(inp[9]), .mbMsgSeen(inp[10]),
      .mbAddrConf(inp[11]), .mbConnTmo(inp[12]), .secLocked(inp[13]),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq), .gwLed(gwLed),
      .eipLed(eipLed), .mbLed(mbLed), .secLed(secLed),
      .statusSym(statusSym));
   gsl_led_watch gw_w (.mclk(mclk), .led(gwLed), .watch(watch),
      .seen(gwSeen));
   gsl_led_watch eip_w (.mclk(mclk), .led(eipLed), .watch(watch),
      .seen(eipSeen));
   gsl_led_watch mb_w (.mclk(mclk), .led(mbLed), .watch(watch),
      .seen(mbSeen));
   gsl_led_watch sec_w (.mclk(mclk), .led({1'b0, secLed}), .watch(watch),
      .seen(secSeen));

   always #25 mclk = ~mclk;

   // Lit and dark must coincide on two flashing indicators
   always @(posedge mclk) begin
      if (watch && ((gwLed != 2'h0) != (eipLed != 2'h0))) begin
         skew++;
      end
   end

   // Codes: 0 dark, 1 green, 2 red, 3 green flash, 4 red flash, 5 both
   function automatic logic [2:0] look(input logic [2:0] s);
      case (s)
         3'h1: return 3'h0;
         3'h2: return 3'h1;
         3'h4: return 3'h2;
         3'h3: return 3'h3;
         3'h5: return 3'h4;
         3'h6, 3'h7: return 3'h5;
         default: return 3'h7;
      endcase
   endfunction : look

   function automatic logic [2:0] gwCls(input logic [13:0] c,
                                        input logic [5:0] p);
      if (c[0] | c[1]) return 3'h2;
      case (p)
         GSL_GW_START: return 3'h3;
         GSL_GW_RUN: return 3'h1;
         GSL_GW_BADCFG: return 3'h4;
         GSL_GW_SELFTEST, GSL_GW_UPDATE: return 3'h5;
         default: return 3'h0;
      endcase
   endfunction : gwCls

   function automatic logic [2:0] linkCls(input logic f, x, a, b, t, u);
      if (f) return 3'h2;
      if (x | !a) return 3'h0;
      if (b) return 3'h2;
      if (t) return 3'h4;
      return u ? 3'h1 : 3'h3;
   endfunction : linkCls

   function automatic logic [1:0] symOf(input logic [13:0] c,
                                        input logic [5:0] p);
      if (c[2] | c[0]) return 2'h3;
      if (c[4] | p == GSL_GW_START | p == GSL_GW_BADCFG |
          (c[5] & !c[6]) | (c[9] & !c[10])) return 2'h1;
      return c[3] ? 2'h2 : 2'h0;
   endfunction : symOf

   task automatic regWrite(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask : regRead

   task automatic tally_and_finish();
      if (errorCnt == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Ceiling well above the 40 vectors of about 31 cycles each
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errorCnt++;
         tally_and_finish();
      end
   end

   initial begin
      w = $urandom(32'hcb63e05c);
      prev = 14'h0;
      repeat (20) @(posedge mclk);
      `CHK("resetOut", 10'h0, {gwLed, eipLed, mbLed, secLed, irq, regRdata[0]})
      `CHK("resetSym", 2'h0, statusSym)
      rst_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         nxt = 14'($urandom);
         w = $urandom;
         nxt[0] = (w[2:0] == 3'h0);
         nxt[1] = (w[5:3] == 3'h0);
         nxt[7] = nxt[7] & w[6];
         nxt[11] = nxt[11] & w[7];
         ph = 6'h01 << (w[10:8] % 6);
         // Fatal and exception with every other source active
         if (i < 2) nxt = i == 0 ? 14'h3fff : 14'h3ffe;
         @(posedge mclk);
         inp <= nxt;
         gwPhase <= ph;
         repeat (8) @(posedge mclk);
         watch <= 1'b1;
         skew = 0;
         repeat (16) @(posedge mclk);
         watch <= 1'b0;
         #1;
         eg = gwCls(nxt, ph);
         ee = linkCls(nxt[0], nxt[1], nxt[5], nxt[7], nxt[8], nxt[6]);
         em = linkCls(nxt[0], nxt[1], nxt[9], nxt[11], nxt[12], nxt[10]);
         `CHK("gwLed", eg, look(gwSeen))
         `CHK("eipLed", ee, look(eipSeen))
         `CHK("mbLed", em, look(mbSeen))
         `CHK("secLed", (nxt[0] | nxt[1] | !nxt[13]) ? 3'h0 : 3'h1, look(secSeen))
         `CHK("statusSym", symOf(nxt, ph), statusSym)
         if ((eg == 3'h3 || eg == 3'h4) && (ee == 3'h3 || ee == 3'h4)) begin
            `CHK("flashSkew", 0, skew)
         end
         rs = ~prev & nxt;
         ev = {prev[13] ^ nxt[13], rs[12], rs[11], rs[8], rs[7], rs[2:0]};
         mask = 8'($urandom);
         regWrite(GSL_ADR_MASK, mask);
         #1;
         `CHK("irqMasked", |(ev & mask), irq)
         `CHK("idleRdata", 8'h00, regRdata)
         regRead(GSL_ADR_STATUS, d);
         `CHK("status", ev, d)
         `CHK("irqCleared", 1'b0, irq)
         regRead(GSL_ADR_INPUT, d);
         `CHK("inputReg", {nxt[0], nxt[1], nxt[2], nxt[13], nxt[5], nxt[6], nxt[9], nxt[10]}, d)
         // Fatal vector holds every lamp steady, so the lamp word is fixed
         if (i == 0) begin
            regRead(GSL_ADR_LEDS, d);
            `CHK("ledsReg", 8'h54, d)
         end
         prev = nxt;
      end
      // Writes to read-only and unmapped places leave the mask alone
      regWrite(GSL_ADR_STATUS, ~mask);
      regWrite(4'h9, ~mask);
      regRead(GSL_ADR_MASK, d);
      `CHK("maskKept", mask, d)
      regRead(4'h9, d);
      `CHK("unmapped", 8'h00, d)
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

/* shared/gsl_flash_if.sv */
// Purpose: Shared flash phase between divider and encoder
// Assumes: One clock domain
// Notes: Phase is a level, tick a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface gsl_flash_if;
   logic phase;
   logic tick;
   modport src (output phase, output tick);
   modport dst (input phase, input tick);
endinterface : gsl_flash_if
`default_nettype wire

/* shared/gsl_pkg.sv */
// Purpose: Constants and types for the gateway status LED encoder
// Assumes: 20 MHz mclk
// Notes: Overview of operation
package gsl_pkg;
   localparam int GSL_FLASH_HALF_NS = 250000000;
   localparam int GSL_CLK_NS = 50;
   localparam int GSL_FLASH_HALF_CYC = GSL_FLASH_HALF_NS / GSL_CLK_NS;
   localparam int GSL_CNT_W = 24;
   // Gateway operating phases
   typedef enum logic [5:0] {
      GSL_GW_OFF = 6'h01,
      GSL_GW_START = 6'h02,
      GSL_GW_RUN = 6'h04,
      GSL_GW_BADCFG = 6'h08,
      GSL_GW_SELFTEST = 6'h10,
      GSL_GW_UPDATE = 6'h20
   } gsl_gw_e;
   // Status symbol codes
   typedef enum logic [1:0] {
      GSL_SYM_NORMAL = 2'h0,
      GSL_SYM_CHECK = 2'h1,
      GSL_SYM_OUTSPEC = 2'h2,
      GSL_SYM_INTERR = 2'h3
   } gsl_sym_e;
   // Indicator colour pair, bit1 red, bit0 green
   localparam logic [1:0] GSL_LED_OFF = 2'h0;
   localparam logic [1:0] GSL_LED_GRN = 2'h1;
   localparam logic [1:0] GSL_LED_RED = 2'h2;
   localparam logic [1:0] GSL_LED_RST = 2'h0;
   localparam logic [7:0] GSL_IRQ_RST = 8'h00;
   localparam logic [7:0] GSL_MASK_RST = 8'h00;
   localparam logic [3:0] GSL_ADR_STATUS = 4'h0;
   localparam logic [3:0] GSL_ADR_MASK = 4'h1;
   localparam logic [3:0] GSL_ADR_LEDS = 4'h2;
   localparam logic [3:0] GSL_ADR_INPUT = 4'h3;
endpackage : gsl_pkg
